/* File: design/rta_match.sv */
// Purpose: per-field alarm comparison with all-ones wildcards
// Assumes: time and alarm use the same coding
// Notes: purely combinational, registered by the caller
module rta_match import rta_pkg::*; (
   input wire rta_alarm_t alm,
   input wire rta_time_t cur,
   input wire logic h12,
   output rta_hits_t hits,
   output logic hit
);
   always_comb
   begin
      // coding-agnostic equality, bcd or binary alike
      hits.mins = (&alm.mins) | (alm.mins == cur.mins);
      hits.secs = (&alm.secs) | (alm.secs == cur.secs);
      hits.wday = (&alm.wday) | (alm.wday == {1'b0, cur.wday});
      // afternoon flag only matters in 12-hour mode
      hits.hpm = !h12 | (alm.hpm == cur.hpm);
      hits.hrs = (&alm.hrs) | (alm.hrs == cur.hrs);
      hits.mth = (&alm.mth) | (alm.mth == cur.mth);
      hits.date = (&alm.date) | (alm.date == cur.date);
      hit = &hits;
   end
endmodule

/* File: design/rta_tickgen.sv */
// Purpose: trimmed one-second tick from the 32.768 khz oscillator pin
// Assumes: oscillator runs free while the tick is enabled
// Notes: trim is read live at every oscillator edge, change it only stopped
module rta_tickgen import rta_pkg::*; (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic osc_pin,
   input wire logic tick_en,
   input wire logic [9:0] trim,
   output logic one_sec_tick,
   output logic tick_sts
);
   rta_tick_st_t s;
   rta_tick_st_t n;
   logic edge_seen;
   logic [6:0] fsum;
   logic [15:0] pm1;

   always_comb
   begin
      n = s;
      n.s1 = osc_pin;
      n.s2 = s.s1;
      n.prev = s.s2;
      edge_seen = s.s2 & !s.prev;
      // integer part adds a signed offset, fraction rolls into a carry
      fsum = {1'b0, s.frac} + {1'b0, trim[5:0]};
      pm1 = RTA_PERIOD_M1 + {{12{trim[9]}}, trim[9:6]} +
         {15'h0000, fsum[6]};
      n.tick = 1'b0;
      if (edge_seen)
      begin
         // stop and start only on an oscillator edge so no period is cut
         n.run = tick_en;
         // a stopping edge neither counts nor ticks, so a status of one
         // never stands beside a tick
         if (s.run & tick_en)
         begin
            if (s.cnt == pm1)
            begin
               n.cnt = 16'h0000;
               n.frac = fsum[5:0];
               n.tick = 1'b1;
            end
            else
               n.cnt = s.cnt + 16'h0001;
         end
      end
      n.sts = !n.run;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         s <= RTA_TICK_RST;
      else
         s <= n;
   end

   assign one_sec_tick = s.tick;
   assign tick_sts = s.sts;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_tick_period;
      s.tick |-> $past(edge_seen) && ($past(s.cnt) == $past(pm1));
   endproperty
   a_tick_period: assert property (p_tick_period)
      else $error("tick not at trimmed period end");

   property p_stopped_quiet;
      s.sts |-> !s.tick;
   endproperty
   a_stopped_quiet: assert property (p_stopped_quiet)
      else $error("tick while stopped");

   property p_cnt_hold;
      !s.run |=> s.cnt == $past(s.cnt);
   endproperty
   a_cnt_hold: assert property (p_cnt_hold)
      else $error("count moved while stopped");

   c_tick: cover property (s.tick);
endmodule

/* File: design/rta_top.sv */
// Purpose: rtc alarm compare, alarm stop handshake and tick trim control
// Assumes: time counters outside give current time and an update pulse
// Notes: registers sit at their index on a plain 16-bit port
// Contract
// - alarm minutes at bits 14:8 of first register, all ones ignores
// - alarm seconds at bits 6:0 of first register, all ones ignores
// - alarm weekday at bits 11:8 of second register, 1 is sunday
// - afternoon flag bit 5, compared only in 12-hour mode
// - alarm hours at bits 4:0 of second register, all ones ignores
// - alarm month at bits 12:8 of third register, all ones ignores
// - alarm day of month at bits 5:0 of third register
// - every all-ones alarm field except the afternoon flag acts as a wildcard
// - match is a level held while all fields equal current time
// - stop request bit 9 resets to one and suppresses alarms
// - stopped status bit 8 resets to one, shows real stop
// - tick generator trims the period for up to 8 hz error
// - matching fields with alarms running raise the alarm event
// - twelve hour select is bit 14 of time control
// - trim is 10-bit two's complement with 6 fraction bits
//
// The address-and-strobe port was decided locally.
module rta_top import rta_pkg::*; (
   input wire logic clk,
   input wire logic rst_b,
   input wire rta_bus_t bus,
   output logic [15:0] rd_data,
   input wire rta_time_t cur_time,
   input wire logic sec_update,
   input wire logic osc_pin,
   output logic one_sec_tick,
   output logic alarm_match,
   output logic alarm_interrupt_event,
   output logic bcd_select,
   output logic twelve_hour_select
);
   rta_top_st_t s;
   rta_top_st_t n;
   rta_hits_t hits;
   logic hit;
   logic tick_sts;
   logic [15:0] rmux;

   function automatic logic at(input logic [7:0] a,
      input logic [7:0] ofs);
      at = (a == ofs);
   endfunction

   rta_match rta_match_inst (
      .alm(s.alm),
      .cur(cur_time),
      .h12(s.h12),
      .hits(hits),
      .hit(hit)
   );

   rta_tickgen rta_tickgen_inst (
      .clk(clk),
      .rst_b(rst_b),
      .osc_pin(osc_pin),
      .tick_en(s.tick_en),
      .trim(s.trim),
      .one_sec_tick(one_sec_tick),
      .tick_sts(tick_sts)
   );

   always_comb
   begin
      n = s;
      rmux = 16'h0000;
      if (bus.wr)
      begin
         if (at(bus.addr, RTA_OFS_ASM))
         begin
            n.alm.mins = bus.wdata[RTA_POS_MIN +: 7];
            n.alm.secs = bus.wdata[RTA_POS_SEC +: 7];
         end
         if (at(bus.addr, RTA_OFS_AHW))
         begin
            n.alm.wday = bus.wdata[RTA_POS_WDAY +: 4];
            n.alm.hpm = bus.wdata[RTA_POS_HPM];
            n.alm.hrs = bus.wdata[RTA_POS_HRS +: 5];
         end
         if (at(bus.addr, RTA_OFS_AMD))
         begin
            n.alm.mth = bus.wdata[RTA_POS_MTH +: 5];
            n.alm.date = bus.wdata[RTA_POS_DATE +: 6];
         end
         if (at(bus.addr, RTA_OFS_TCTL))
         begin
            n.bcd = bus.wdata[RTA_POS_BCD];
            n.h12 = bus.wdata[RTA_POS_H12];
            n.stop = bus.wdata[RTA_POS_STOP];
         end
         if (at(bus.addr, RTA_OFS_PWR))
            n.tick_en = bus.wdata[RTA_POS_TICK_EN];
         if (at(bus.addr, RTA_OFS_TRIM))
            n.trim = bus.wdata[RTA_POS_TRIM +: 10];
      end
      if (at(bus.addr, RTA_OFS_ASM))
      begin
         rmux[RTA_POS_MIN +: 7] = s.alm.mins;
         rmux[RTA_POS_SEC +: 7] = s.alm.secs;
      end
      if (at(bus.addr, RTA_OFS_AHW))
      begin
         rmux[RTA_POS_WDAY +: 4] = s.alm.wday;
         rmux[RTA_POS_HPM] = s.alm.hpm;
         rmux[RTA_POS_HRS +: 5] = s.alm.hrs;
      end
      if (at(bus.addr, RTA_OFS_AMD))
      begin
         rmux[RTA_POS_MTH +: 5] = s.alm.mth;
         rmux[RTA_POS_DATE +: 6] = s.alm.date;
      end
      if (at(bus.addr, RTA_OFS_TCTL))
      begin
         rmux[RTA_POS_BCD] = s.bcd;
         rmux[RTA_POS_H12] = s.h12;
         rmux[RTA_POS_STOP] = s.stop;
         rmux[RTA_POS_STS] = s.sts;
      end
      if (at(bus.addr, RTA_OFS_PWR))
         rmux[RTA_POS_TICK_EN] = s.tick_en;
      if (at(bus.addr, RTA_OFS_TRIM))
      begin
         rmux[RTA_POS_TICK_STS] = tick_sts;
         rmux[RTA_POS_TRIM +: 10] = s.trim;
      end
      // read data stand only in the cycle after the strobe
      n.rdata = bus.rd ? rmux : 16'h0000;
      // status lags the request by one cycle: the match stage has then
      // already been cleared, so a poll that sees one is truly safe
      n.sts = s.stop;
      // the match level is refreshed only on a seconds update, so half
      // written time counters are never compared
      if (s.stop)
         n.match = 1'b0;
      else if (sec_update)
         n.match = hit;
      // one event per rising match, a long wildcard level fires once
      n.evt = !s.stop & sec_update & hit & !s.match;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         s <= RTA_TOP_RST;
      else
         s <= n;
   end

   assign rd_data = s.rdata;
   assign alarm_match = s.match;
   assign alarm_interrupt_event = s.evt;
   assign bcd_select = s.bcd;
   assign twelve_hour_select = s.h12;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_stop_quiet;
      s.stop |=> !s.evt && !s.match;
   endproperty
   a_stop_quiet: assert property (p_stop_quiet)
      else $error("alarm activity while stopped");

   property p_sts_follows;
      s.stop ##1 s.stop |-> s.sts;
   endproperty
   a_sts_follows: assert property (p_sts_follows)
      else $error("stopped status missing");

   property p_sts_clear;
      !s.stop ##1 !s.stop |-> !s.sts;
   endproperty
   a_sts_clear: assert property (p_sts_clear)
      else $error("stopped status stuck");

   property p_evt_cause;
      s.evt |-> s.match && !$past(s.match) && $past(sec_update);
   endproperty
   a_evt_cause: assert property (p_evt_cause)
      else $error("event without new match");

   property p_match_hold;
      !sec_update && !s.stop |=> s.match == $past(s.match);
   endproperty
   a_match_hold: assert property (p_match_hold)
      else $error("match changed without update");

   property p_match_take;
      sec_update && !s.stop |=> s.match == $past(hit);
   endproperty
   a_match_take: assert property (p_match_take)
      else $error("match not taken at update");

   property p_sec_wild;
      (&s.alm.secs) |-> hits.secs;
   endproperty
   a_sec_wild: assert property (p_sec_wild)
      else $error("seconds wildcard ignored");

   property p_min_wild;
      (&s.alm.mins) |-> hits.mins;
   endproperty
   a_min_wild: assert property (p_min_wild)
      else $error("minutes wildcard ignored");

   property p_wday_cmp;
      !(&s.alm.wday) && s.alm.wday != {1'b0, cur_time.wday}
         |-> !hits.wday;
   endproperty
   a_wday_cmp: assert property (p_wday_cmp)
      else $error("weekday mismatch accepted");

   property p_hpm_24h;
      !s.h12 |-> hits.hpm;
   endproperty
   a_hpm_24h: assert property (p_hpm_24h)
      else $error("afternoon flag compared in 24-hour mode");

   property p_hrs_cmp;
      !(&s.alm.hrs) && s.alm.hrs != cur_time.hrs |-> !hit;
   endproperty
   a_hrs_cmp: assert property (p_hrs_cmp)
      else $error("hours mismatch accepted");

   property p_mth_date_wild;
      (&s.alm.mth) && (&s.alm.date) |-> hits.mth && hits.date;
   endproperty
   a_mth_date_wild: assert property (p_mth_date_wild)
      else $error("month or date wildcard ignored");

   property p_rd_window;
      !bus.rd |=> rd_data == 16'h0000;
   endproperty
   a_rd_window: assert property (p_rd_window)
      else $error("read data outside read cycle");

   property p_min_cmp;
      !(&s.alm.mins) && s.alm.mins != cur_time.mins |-> !hit;
   endproperty
   a_min_cmp: assert property (p_min_cmp)
      else $error("minutes mismatch accepted");

   property p_sec_cmp;
      !(&s.alm.secs) && s.alm.secs != cur_time.secs |-> !hit;
   endproperty
   a_sec_cmp: assert property (p_sec_cmp)
      else $error("seconds mismatch accepted");

   property p_mth_cmp;
      !(&s.alm.mth) && s.alm.mth != cur_time.mth |-> !hit;
   endproperty
   a_mth_cmp: assert property (p_mth_cmp)
      else $error("month mismatch accepted");

   property p_date_cmp;
      !(&s.alm.date) && s.alm.date != cur_time.date |-> !hit;
   endproperty
   a_date_cmp: assert property (p_date_cmp)
      else $error("day of month mismatch accepted");

   property p_wday_wild;
      (&s.alm.wday) |-> hits.wday;
   endproperty
   a_wday_wild: assert property (p_wday_wild)
      else $error("weekday wildcard ignored");

   property p_hrs_wild;
      (&s.alm.hrs) |-> hits.hrs;
   endproperty
   a_hrs_wild: assert property (p_hrs_wild)
      else $error("hours wildcard ignored");

   property p_hpm_12h;
      s.h12 && s.alm.hpm != cur_time.hpm
         |-> !hit;
   endproperty
   a_hpm_12h: assert property (p_hpm_12h)
      else $error("afternoon mismatch accepted in 12-hour mode");

   property p_evt_pulse;
      s.evt |=> !s.evt;
   endproperty
   a_evt_pulse: assert property (p_evt_pulse)
      else $error("alarm event longer than one cycle");

   property p_evt_run;
      s.evt |-> !$past(s.stop);
   endproperty
   a_evt_run: assert property (p_evt_run)
      else $error("alarm event while stopped");

   property p_sts_rd;
      bus.rd && bus.addr == RTA_OFS_TCTL
         |=> rd_data[RTA_POS_STS] == $past(s.sts);
   endproperty
   a_sts_rd: assert property (p_sts_rd)
      else $error("stopped status misread");

   property p_tick_sts_rd;
      bus.rd && bus.addr == RTA_OFS_TRIM
         |=> rd_data[RTA_POS_TICK_STS] == $past(tick_sts);
   endproperty
   a_tick_sts_rd: assert property (p_tick_sts_rd)
      else $error("tick status misread");

   property p_wr_ro;
      bus.wr && bus.addr == RTA_OFS_TCTL
         |=> s.sts == $past(s.stop);
   endproperty
   a_wr_ro: assert property (p_wr_ro)
      else $error("stopped status written by software");

   c_alarm_event: cover property (s.evt);
   c_long_match: cover property (s.match [*3]);
   c_stop_handshake: cover property (s.stop ##1 s.sts ##[1:20] !s.stop);
   c_tick_stopped: cover property (!s.tick_en ##[1:1000] tick_sts);
endmodule

/* File: include/rta_pkg.sv */
// Purpose: shared constants and types for the rtc alarm and trim block
// Assumes: 16-bit register port, byte-wide register index
// Notes: offsets are register indices on the plain port
package rta_pkg;
   localparam logic [7:0] RTA_OFS_PWR = 8'h0c;
   localparam logic [7:0] RTA_OFS_ASM = 8'h14;
   localparam logic [7:0] RTA_OFS_AHW = 8'h15;
   localparam logic [7:0] RTA_OFS_AMD = 8'h16;
   localparam logic [7:0] RTA_OFS_TCTL = 8'h17;
   localparam logic [7:0] RTA_OFS_TRIM = 8'hda;
   localparam int RTA_POS_MIN = 8;
   localparam int RTA_POS_SEC = 0;
   localparam int RTA_POS_WDAY = 8;
   localparam int RTA_POS_HPM = 5;
   localparam int RTA_POS_HRS = 0;
   localparam int RTA_POS_MTH = 8;
   localparam int RTA_POS_DATE = 0;
   localparam int RTA_POS_BCD = 15;
   localparam int RTA_POS_H12 = 14;
   localparam int RTA_POS_STOP = 9;
   localparam int RTA_POS_STS = 8;
   localparam int RTA_POS_TICK_EN = 11;
   localparam int RTA_POS_TICK_STS = 14;
   localparam int RTA_POS_TRIM = 0;
   // nominal oscillator edges per second, minus one
   localparam logic [15:0] RTA_PERIOD_M1 = 16'h7fff;
   typedef struct packed {
      logic [6:0] mins;
      logic [6:0] secs;
      logic [3:0] wday;
      logic hpm;
      logic [4:0] hrs;
      logic [4:0] mth;
      logic [5:0] date;
   } rta_alarm_t;
   typedef struct packed {
      logic [6:0] mins;
      logic [6:0] secs;
      logic [2:0] wday;
      logic hpm;
      logic [4:0] hrs;
      logic [4:0] mth;
      logic [5:0] date;
   } rta_time_t;
   typedef struct packed {
      logic mins;
      logic secs;
      logic wday;
      logic hpm;
      logic hrs;
      logic mth;
      logic date;
   } rta_hits_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } rta_bus_t;
   typedef struct packed {
      rta_alarm_t alm;
      logic bcd;
      logic h12;
      logic stop;
      logic sts;
      logic tick_en;
      logic [9:0] trim;
      logic match;
      logic evt;
      logic [15:0] rdata;
   } rta_top_st_t;
   localparam rta_top_st_t RTA_TOP_RST = '{alm: '0, bcd: 1'b0,
      h12: 1'b0, stop: 1'b1, sts: 1'b1, tick_en: 1'b1, trim: 10'h000,
      match: 1'b0, evt: 1'b0, rdata: 16'h0000};
   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
      logic run;
      logic [15:0] cnt;
      logic [5:0] frac;
      logic tick;
      logic sts;
   } rta_tick_st_t;
   localparam rta_tick_st_t RTA_TICK_RST = '{s1: 1'b0, s2: 1'b0,
      prev: 1'b0, run: 1'b0, cnt: 16'h0000, frac: 6'h00, tick: 1'b0,
      sts: 1'b1};
endpackage

/* File: verification/rta_top_tb.sv */
// Purpose: self-checking bench for the rtc alarm and trim block
// Assumes: outside time counters are modelled by a fixed cur_time
// Notes: one trimmed second is run at the end, oscillator at full speed
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
 $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module rta_top_tb import rta_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk;
   logic rst_b;
   rta_bus_t bus;
   logic [15:0] rd_data;
   rta_time_t cur_time;
   logic sec_update;
   logic osc_pin;
   logic one_sec_tick;
   logic alarm_match;
   logic alarm_interrupt_event;
   logic bcd_select;
   logic twelve_hour_select;
   int error_cnt;
   int tests_run;
   logic [31:0] seed;
   logic [15:0] rq[$];
   logic [1:0] aq[$];
   logic rd_p;
   logic up_p;
   logic [15:0] v;
   logic [15:0] rexp;
   logic [1:0] aexp;
   int texp;
   int tq[$];
   int ticks;
   int osc_rises;
   logic osc_go = 1'b0;
   rta_top rta_top_inst (
      .clk(clk),
      .rst_b(rst_b),
      .bus(bus),
      .rd_data(rd_data),
      .cur_time(cur_time),
      .sec_update(sec_update),
      .osc_pin(osc_pin),
      .one_sec_tick(one_sec_tick),
      .alarm_match(alarm_match),
      .alarm_interrupt_event(alarm_interrupt_event),
      .bcd_select(bcd_select),
      .twelve_hour_select(twelve_hour_select)
   );
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      rq.push_back(e);
      @(posedge clk);
      bus <= '0;
   endtask
   // one update pulse and the expected {match, event} after it
   task automatic upd(input logic m, input logic e);
      @(posedge clk);
      sec_update <= 1'b1;
      aq.push_back({m, e});
      @(posedge clk);
      sec_update <= 1'b0;
   endtask
   // mismatch a field, wildcard it, then restore the matching value
   task automatic fld(input logic [7:0] a, input logic [15:0] b,
      input logic [15:0] m);
      wr(a, b ^ (m & (~m + 16'h0001)));
      upd(1'b0, 1'b0);
      wr(a, b | m);
      upd(1'b1, 1'b1);
      wr(a, b);
      upd(1'b1, 1'b0);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // oscillator held until the trim is set, then one rise per two clocks
   // so that a whole trimmed second fits in the run
   initial
   begin
      osc_pin = 1'b0;
      osc_rises = 0;
      wait (osc_go);
      forever
      begin
         @(posedge clk);
         osc_pin <= ~osc_pin;
         if (!osc_pin)
            osc_rises++;
      end
   end
   always @(posedge clk)
   begin
      rd_p <= bus.rd;
      up_p <= sec_update;
   end
   // results settle by the falling edge after the answering edge
   always @(negedge clk)
   begin
      if (rd_p === 1'b1)
      begin
         rexp = rq.pop_front();
         `CHK(rd_data, rexp)
      end
      if (up_p === 1'b1)
      begin
         aexp = aq.pop_front();
         `CHK({alarm_match, alarm_interrupt_event}, aexp)
      end
      if (one_sec_tick === 1'b1)
      begin
         ticks++;
         texp = tq.pop_front();
         `CHK(osc_rises, texp)
      end
   end
   // a trimmed second takes about 65536 clocks, the rest a few hundred
   initial
   begin
      repeat (80000) @(posedge clk);
      error_cnt++;
      print_verdict();
   end
   initial
   begin
      error_cnt = 0;
      tests_run = 0;
      ticks = 0;
      seed = 32'd47;
      rst_b = 1'b0;
      bus = '0;
      sec_update = 1'b0;
      rd_p = 1'b0;
      up_p = 1'b0;
      cur_time = '{mins: 7'h1e, secs: 7'h2d, wday: 3'h3, hpm: 1'b1,
         hrs: 5'h05, mth: 5'h06, date: 6'h11};
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      rd(RTA_OFS_TCTL, 16'h0300);
      rd(8'h20, 16'h0000);
      for (int i = 0; i < 6; i++)
      begin
         seed = xs(seed);
         v = seed[15:0];
         wr(RTA_OFS_ASM + 8'(i % 3), v);
         rd(RTA_OFS_ASM + 8'(i % 3), v & (i % 3 == 0 ? 16'h7f7f :
            i % 3 == 1 ? 16'h0f3f : 16'h1f3f));
      end
      wr(RTA_OFS_PWR, 16'h0000);
      repeat (60) @(posedge clk);
      rd(RTA_OFS_TRIM, 16'h4000);
      seed = xs(seed);
      v = seed[15:0] & 16'h03ff;
      wr(RTA_OFS_TRIM, v);
      rd(RTA_OFS_TRIM, 16'h4000 | v);
      wr(RTA_OFS_TRIM, 16'h03c0);
      rd(RTA_OFS_TRIM, 16'h43c0);
      wr(RTA_OFS_PWR, 16'h0800);
      rd(RTA_OFS_PWR, 16'h0800);
      wr(RTA_OFS_ASM, 16'h1e2d);
      wr(RTA_OFS_AHW, 16'h0305);
      wr(RTA_OFS_AMD, 16'h0611);
      upd(1'b0, 1'b0);
      wr(RTA_OFS_TCTL, 16'h0000);
      repeat (3) @(posedge clk);
      rd(RTA_OFS_TCTL, 16'h0000);
      upd(1'b1, 1'b1);
      upd(1'b1, 1'b0);
      fld(RTA_OFS_ASM, 16'h1e2d, 16'h7f00);
      fld(RTA_OFS_ASM, 16'h1e2d, 16'h007f);
      fld(RTA_OFS_AHW, 16'h0305, 16'h0f00);
      fld(RTA_OFS_AHW, 16'h0305, 16'h003f);
      fld(RTA_OFS_AMD, 16'h0611, 16'h1f00);
      fld(RTA_OFS_AMD, 16'h0611, 16'h003f);
      wr(RTA_OFS_AHW, 16'h0305);
      upd(1'b1, 1'b0);
      wr(RTA_OFS_TCTL, 16'h4000);
      upd(1'b0, 1'b0);
      wr(RTA_OFS_AHW, 16'h0325);
      upd(1'b1, 1'b1);
      wr(RTA_OFS_TCTL, 16'h4200);
      upd(1'b0, 1'b0);
      wr(RTA_OFS_TCTL, 16'hc2ff);
      rd(RTA_OFS_TCTL, 16'hc300);
      repeat (3) @(posedge clk);
      `CHK({bcd_select, twelve_hour_select}, 2'b11)
      // trim -1 hz: an arming rise, 32767 rises to the tick, and one more
      // rise driven while the edge crosses the synchroniser
      tq.push_back(32769);
      osc_go = 1'b1;
      repeat (12) @(posedge clk);
      rd(RTA_OFS_TRIM, 16'h03c0);
      while (ticks == 0)
         @(posedge clk);
      repeat (8) @(posedge clk);
      `CHK(ticks, 1)
      print_verdict();
   end
endmodule
